// >>> hdl/isz_defines.vh
/*
 Constants for the four-instruction execute block: opcode patterns, field
 positions, register offsets and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ISZ_DEFINES_VH
`define ISZ_DEFINES_VH
`define ISZ_OP_INC_SKIP   6'h0F
`define ISZ_OP_OR_FILE    6'h04
`define ISZ_OP_OR_LIT     6'h38
`define ISZ_OP_LOAD_LIT   4'hC
`define ISZ_OP_HI         13
`define ISZ_OP_LO         8
`define ISZ_DEST_BIT      7
`define ISZ_FADDR_HI      6
`define ISZ_LIT_HI        7
`define ISZ_ADDR_W        3
`define ISZ_REG_W         3'h0
`define ISZ_REG_STATUS    3'h1
`define ISZ_REG_EXEC      3'h2
`define ISZ_REG_SKIPCNT   3'h3
`define ISZ_W_RST         8'h00
`define ISZ_Z_RST         1'b0
`endif

// >>> hdl/isz_file_ram.v
/*
 128 x 8 file register memory with one write port and a registered read.
 Assumes a single clock; read data appear the cycle after the address.
*/
`timescale 1ns/1ps
module isz_file_ram (
   // Clock
   input  wire       i_sys_clk,
   // Write port
   input  wire       i_we,
   input  wire [6:0] i_waddr,
   input  wire [7:0] i_wdata,
   // Read port
   input  wire [6:0] i_raddr,
   output reg  [7:0] o_rdata
);
   reg [7:0] mem_r [0:127];

   always @(posedge i_sys_clk) begin
      if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_r[i_raddr];
   end
endmodule

// >>> hdl/isz_exec.v
/*
 Execute block for increment-skip-zero, OR W with file (to W or file), OR literal into W and
 load literal to W. Instructions arrive one per i_instr_valid pulse; each taken word
 takes two clock cycles here (operand read, then execute), and the block
 holds o_busy while it works. A zero increment result also raises a skip
 that swallows the next offered instruction, executed as a no-operation.
 Assumes the fetch side waits for o_busy low before offering the next word.
 File registers are not cleared by reset; software must seed them before use.
*/
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "isz_defines.vh"
module isz_exec (
   // Clock and reset
   input  wire        i_sys_clk,
   input  wire        i_rst,
   // Instruction in
   input  wire        i_instr_valid,
   input  wire [13:0] i_instr,
   // Register port
   input  wire [2:0]  i_addr,
   input  wire [7:0]  i_wdata,
   input  wire        i_wr,
   input  wire        i_rd,
   output reg  [7:0]  o_rdata,
   // Status out
   output reg         o_busy,
   output reg         o_skip,
   output reg  [7:0]  o_w,
   output reg         o_zero,
   output reg         o_done
);
   localparam ST_IDLE = 2'b01;
   localparam ST_EXEC = 2'b10;

   reg  [1:0]  state_r;
   reg  [13:0] instr_r;
   reg         skip_pend_r;
   reg  [7:0]  skip_cnt_r;
   reg  [7:0]  res_nxt;
   reg         wr_w_nxt;
   reg         wr_f_nxt;
   reg         upd_z_nxt;
   reg         skip_nxt;
   reg  [1:0]  state_nxt;
   reg  [7:0]  skip_cnt_nxt;
   reg  [7:0]  rdata_nxt;
   wire [7:0]  or_file_v;
   wire [7:0]  or_lit_v;
   wire [7:0]  file_q;
   wire [5:0]  op6  = instr_r[`ISZ_OP_HI:`ISZ_OP_LO];
   wire        dbit = instr_r[`ISZ_DEST_BIT];
   wire [7:0]  lit  = instr_r[`ISZ_LIT_HI:0];
   wire [7:0]  inc_sum = file_q + 8'h01;
   wire        res_zero = ~|res_nxt;

   // One slice per data bit builds both OR results side by side. The decode
   // below picks one of them, so the wide OR is never duplicated per opcode
   // and the zero reduction always sees the value that is written back.
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
         assign or_file_v[gi] = o_w[gi] | file_q[gi];
         assign or_lit_v[gi]  = o_w[gi] | lit[gi];
      end
   endgenerate

   isz_file_ram u_ram (
      .i_sys_clk (i_sys_clk),
      .i_we      (wr_f_nxt && state_r == ST_EXEC),
      .i_waddr   (instr_r[`ISZ_FADDR_HI:0]),
      .i_wdata   (res_nxt),
      .i_raddr   (i_instr[`ISZ_FADDR_HI:0]),
      .o_rdata   (file_q)
   );

   // Decode of the latched word; file operand is valid in ST_EXEC.
   always @* begin
      res_nxt   = 8'h00;
      wr_w_nxt  = 1'b0;
      wr_f_nxt  = 1'b0;
      upd_z_nxt = 1'b0;
      skip_nxt  = 1'b0;
      if (op6 == `ISZ_OP_INC_SKIP) begin
         res_nxt  = inc_sum;
         wr_w_nxt = ~dbit;
         wr_f_nxt = dbit;
         skip_nxt = (inc_sum == 8'h00);
      end else if (op6 == `ISZ_OP_OR_FILE) begin
         res_nxt   = or_file_v;
         wr_w_nxt  = ~dbit;
         wr_f_nxt  = dbit;
         upd_z_nxt = 1'b1;
      end else if (op6 == `ISZ_OP_OR_LIT) begin
         res_nxt   = or_lit_v;
         wr_w_nxt  = 1'b1;
         upd_z_nxt = 1'b1;
      end else if (op6[5:2] == `ISZ_OP_LOAD_LIT) begin
         res_nxt  = lit;
         wr_w_nxt = 1'b1;
      end
   end

   // Execute-side registers. The W write from the register port sits after
   // the case so that, in idle, software wins; in execute it is refused so an
   // instruction never sees W change under it between read and write back.
   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         instr_r     <= 14'h0000;
         skip_pend_r <= 1'b0;
         o_busy      <= 1'b0;
         o_skip      <= 1'b0;
         o_w         <= `ISZ_W_RST;
         o_zero      <= `ISZ_Z_RST;
         o_done      <= 1'b0;
      end else begin
         o_done <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (i_instr_valid) begin
                  if (skip_pend_r) begin
                     // Prefetched word is dropped; this cycle is the no-op.
                     skip_pend_r <= 1'b0;
                     o_skip      <= 1'b0;
                     o_done      <= 1'b1;
                  end else begin
                     instr_r <= i_instr;
                     o_busy  <= 1'b1;
                  end
               end
            end
            ST_EXEC: begin
               if (wr_w_nxt) begin
                  o_w <= res_nxt;
               end
               if (upd_z_nxt) begin
                  o_zero <= res_zero;
               end
               if (skip_nxt) begin
                  skip_pend_r <= 1'b1;
                  o_skip      <= 1'b1;
               end
               o_busy  <= 1'b0;
               o_done  <= 1'b1;
            end
            default: begin
               o_busy <= 1'b0;
            end
         endcase
         // Software writes to W only land when no instruction is executing.
         if (i_wr && state_r == ST_IDLE && i_addr == `ISZ_REG_W) begin
            o_w <= i_wdata;
         end
      end
   end

   // Sequencer: a taken word always costs one execute cycle, while a word
   // offered under a pending skip is consumed in place and never enters it.
   // An illegal state code falls back to idle rather than hanging the core.
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (i_instr_valid && !skip_pend_r) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Wrapping count of skips taken. It is a debug aid only; an 8-bit wrap
   // was judged cheaper than a saturating counter nobody would clear.
   always @* begin
      skip_cnt_nxt = skip_cnt_r;
      if (state_r == ST_EXEC && skip_nxt) begin
         skip_cnt_nxt = skip_cnt_r + 8'h01;
      end
   end

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         skip_cnt_r <= 8'h00;
      end else begin
         skip_cnt_r <= skip_cnt_nxt;
      end
   end

   // Read data are chosen here and held in a flop below, so a read sees the
   // state as it stood at the strobe edge and o_rdata holds until the next read.
   always @* begin
      rdata_nxt = o_rdata;
      if (i_rd) begin
         case (i_addr)
            `ISZ_REG_W:       rdata_nxt = o_w;
            `ISZ_REG_STATUS:  rdata_nxt = {5'h00, skip_pend_r, o_busy, o_zero};
            `ISZ_REG_EXEC:    rdata_nxt = {2'h0, op6};
            `ISZ_REG_SKIPCNT: rdata_nxt = skip_cnt_r;
            default:          rdata_nxt = 8'h00;
         endcase
      end
   end

   always @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= rdata_nxt;
      end
   end
endmodule

// >>> test/isz_exec_properties.sv
/* Port checker for isz_exec.
 Assumes the bench clock and reset; bound into every isz_exec. */
`timescale 1ns/1ps
`include "isz_defines.vh"
module isz_exec_properties (
   input wire        i_sys_clk,
   input wire        i_rst,
   input wire        i_instr_valid,
   input wire [13:0] i_instr,
   input wire [7:0]  o_w,
   input wire        o_busy,
   input wire        o_skip,
   input wire        o_zero,
   input wire        o_done
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   wire       t  = i_instr_valid & ~o_busy & ~o_skip;
   wire       s  = i_instr_valid & ~o_busy & o_skip;
   wire [5:0] op = i_instr[13:8];
   a_take_busy:
   assert property (t |=> o_busy) else $error("taken word did not start");
   a_busy_done:
   assert property (o_busy |=> o_done && !o_busy) else $error("execute did not finish");
   a_load_lit:
   assert property (t && op[5:2] == 4'hC |=> ##1 o_w == $past(i_instr[7:0], 2) && o_zero == $past(o_zero, 2))
      else $error("literal load wrong");
   a_or_lit:
   assert property (t && op == `ISZ_OP_OR_LIT |=> ##1 o_w == ($past(o_w, 2) | $past(i_instr[7:0], 2))
      && o_zero == (o_w == 8'h00)) else $error("literal or wrong");
   a_inc_flags:
   assert property (t && op == `ISZ_OP_INC_SKIP |=> ##1 o_zero == $past(o_zero, 2)) else $error("inc moved flag");
   a_inc_skip:
   assert property (t && op == `ISZ_OP_INC_SKIP && !i_instr[7] |=> ##1 o_skip == (o_w == 8'h00))
      else $error("skip not tied to zero result");
   a_or_file_z:
   assert property (t && op == `ISZ_OP_OR_FILE && !i_instr[7] |=> ##1 o_zero == (o_w == 8'h00)
      && (o_w & $past(o_w, 2)) == $past(o_w, 2)) else $error("file or wrong");
   a_skip_noop:
   assert property (s |=> o_done && !o_busy && !o_skip && o_w == $past(o_w)) else $error("skipped word acted");
   cover property (s);
   cover property (t && op == `ISZ_OP_OR_FILE);
   cover property (o_done && o_zero);
endmodule
bind isz_exec isz_exec_properties u_chk (.i_sys_clk, .i_rst, .i_instr_valid, .i_instr, .o_w, .o_busy, .o_skip,
   .o_zero, .o_done);

// >>> test/isz_exec_tb.sv
/* Self-checking bench for isz_exec.
 Assumes the checker is bound in; file memory starts unknown, so it is seeded by OR. */
`timescale 1ns/1ps
module isz_exec_tb;
   reg        i_sys_clk = 1'b0;
   reg        i_rst = 1'b1;
   reg        i_instr_valid = 1'b0;
   reg [13:0] i_instr = 14'h0000;
   reg [2:0]  i_addr = 3'h0;
   reg [7:0]  i_wdata = 8'h00;
   reg        i_wr = 1'b0;
   reg        i_rd = 1'b0;
   wire [7:0] o_rdata, o_w;
   wire       o_busy, o_skip, o_zero, o_done;
   integer    fail_count = 0;
   integer    checks = 0;
   always #4 i_sys_clk = ~i_sys_clk;
   isz_exec u_dut (.i_sys_clk, .i_rst, .i_instr_valid, .i_instr, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .o_busy, .o_skip, .o_w, .o_zero, .o_done);
   task chk(input [7:0] got, input [7:0] exp); begin
      checks = checks + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end endtask
   task test_done; begin
      if (fail_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   end endtask
   // Flags are {skip, zero}; done must pulse in the cycle we look.
   task ex(input [13:0] ins, input [7:0] w, input [1:0] f); integer n; begin
      @(posedge i_sys_clk);
      i_instr <= ins;
      i_instr_valid <= 1'b1;
      @(posedge i_sys_clk);
      i_instr_valid <= 1'b0;
      n = 0;
      #1;
      while (o_done !== 1'b1 && n < 3) begin
         @(posedge i_sys_clk);
         #1;
         n = n + 1;
      end
      chk({5'h00, o_skip, o_zero, o_done}, {5'h00, f, 1'b1});
      chk(o_w, w);
   end endtask
   task wr(input [2:0] a, input [7:0] d); begin
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   end endtask
   task rd(input [2:0] a, input [7:0] e); begin
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, e);
   end endtask
   initial begin
      repeat (5) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      wr(3'h0, 8'h9A);
      rd(3'h0, 8'h9A);
      rd(3'h7, 8'h00);
      ex(14'h3835, 8'hBF, 2'b00);
      ex(14'h3300, 8'h00, 2'b00);
      ex(14'h3800, 8'h00, 2'b01);
      ex(14'h315A, 8'h5A, 2'b01);
      wr(3'h0, 8'hFF);
      ex(14'h04FF, 8'hFF, 2'b00);
      ex(14'h0F7F, 8'h00, 2'b10);
      ex(14'h3077, 8'h00, 2'b00);
      ex(14'h0FFF, 8'h00, 2'b10);
      ex(14'h3277, 8'h00, 2'b00);
      wr(3'h0, 8'h13);
      ex(14'h047F, 8'h13, 2'b00);
      ex(14'h3000, 8'h00, 2'b00);
      ex(14'h047F, 8'h00, 2'b01);
      rd(3'h1, 8'h01);
      rd(3'h2, 8'h04);
      rd(3'h3, 8'h02);
      test_done;
   end
   initial begin
      repeat (2000) @(posedge i_sys_clk);
      fail_count = fail_count + 1;
      test_done;
   end
endmodule
